// *** qmtsr_chk.sv ***
// Port checker for the transmit status and receive control slice.
// Assumes a bind onto qmtsr_top.
`timescale 1ns/10ps
module qmtsr_chk (
   input        ref_clk_i,
   input        rst_n_i,
   input [8:0]  bus_addr_i,
   input        bus_wr_i,
   input        bus_rd_i,
   input [1:0]  bus_be_i,
   input [15:0] bus_wdata_i,
   input [15:0] bus_rdata_o,
   input        bus_rvalid_o,
   input        tx_done_i,
   input        tx_late_col_i,
   input        tx_max_col_i,
   input [5:0]  tx_frame_id_i,
   input        full_duplex_i,
   input        pause_req_i,
   input [15:0] pause_quanta_i,
   input        tx_hold_o,
   input        q_valid_o,
   input        receive_run_en_o,
   input        rx_queue_flush_o,
   input [10:0] rx_frame_ptr_o
);
   reg  pause_en_q;
   wire wr_ctl = bus_wr_i && bus_addr_i == 9'h174;
   // Pause enable is no port: shadowed from bus writes
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         pause_en_q <= 1'b0;
      else if (wr_ctl && bus_be_i[1])
         pause_en_q <= bus_wdata_i[10];
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_done_read;
      tx_done_i ##1 (bus_rd_i && bus_addr_i == 9'h172 && !tx_done_i);
   endsequence
   a_read_pulse: assert property (bus_rd_i |=> bus_rvalid_o)
      else $error("read not answered");
   a_status_word: assert property (s_done_read |=> bus_rdata_o == {2'b00,
      $past(tx_late_col_i, 2), $past(tx_max_col_i, 2), 6'h00, $past(tx_frame_id_i, 2)})
      else $error("status word wrong");
   a_unmapped_zero: assert property (bus_rd_i && bus_addr_i != 9'h172 && bus_addr_i != 9'h174
      |=> bus_rdata_o == 16'h0000) else $error("unmapped read not zero");
   a_flush_level: assert property (wr_ctl && bus_be_i[1]
      |=> rx_queue_flush_o == $past(bus_wdata_i[15])) else $error("flush level wrong");
   a_run_level: assert property (wr_ctl && bus_be_i[0]
      |=> receive_run_en_o == $past(bus_wdata_i[0])) else $error("run level wrong");
   a_flush_clears: assert property (rx_queue_flush_o [*2]
      |-> rx_frame_ptr_o == 11'h000 && !q_valid_o) else $error("flush left data");
   a_half_duplex: assert property (!full_duplex_i |=> !tx_hold_o)
      else $error("hold in half duplex");
   a_pause_start: assert property (pause_req_i && pause_en_q && full_duplex_i
      && pause_quanta_i != 16'h0000 |=> tx_hold_o) else $error("pause not obeyed");
   a_pause_ignore: assert property (pause_req_i && !pause_en_q && !tx_hold_o
      |=> !tx_hold_o) else $error("pause not ignored");
endmodule

// *** qmtsr_defines.vh ***
// Register map, field positions, reset values and timing for the
// transmit status and receive control slice of the queue manager.
// Assumes a 16-bit host bus addressed in bytes.
`ifndef QMTSR_DEFINES_VH
`define QMTSR_DEFINES_VH

`define QMTSR_ADDR_W            9
`define QMTSR_TX_STATUS_ADDR    9'h172
`define QMTSR_RX_CTRL_ONE_ADDR  9'h174

`define QMTSR_TXS_LATE_COL      13
`define QMTSR_TXS_MAX_COL       12
`define QMTSR_TXS_FID_HI        5
`define QMTSR_TXS_FID_LO        0

`define QMTSR_RXC_FLUSH         15
`define QMTSR_RXC_UDP_CHK       14
`define QMTSR_RXC_TCP_CHK       13
`define QMTSR_RXC_IP_CHK        12
`define QMTSR_RXC_UCAST_FILT    11
`define QMTSR_RXC_PAUSE_EN      10
`define QMTSR_RXC_CRC_ACCEPT    9
`define QMTSR_RXC_MCAST_FILT    8
`define QMTSR_RXC_RUN_EN        0

`define QMTSR_TX_STATUS_RESET   16'h0000
`define QMTSR_RX_CTRL_RESET     16'h0800

// Pause quantum is 512 bit times; at 100 Mb/s that is 5120 ns
`define QMTSR_CLK_PERIOD_NS     5
`define QMTSR_QUANTUM_NS        5120
`define QMTSR_QUANTUM_CYC       ((`QMTSR_QUANTUM_NS + `QMTSR_CLK_PERIOD_NS - 1) / `QMTSR_CLK_PERIOD_NS)

`endif

// *** qmtsr_fifo.v ***
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/10ps
module qmtsr_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             ref_clk_i,
   input  wire             rst_n_i,
   input  wire             flush_i,
   input  wire             in_valid_i,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             in_ready_o,
   output wire             out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input  wire             out_ready_i
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_q;
   reg  [AW-1:0]    rd_ptr_q;
   reg  [AW:0]      count_q;
   reg              full_q;
   reg              empty_q;
   wire             push;
   wire             pop;
   wire [AW:0]      count_d;

   assign push        = in_valid_i & ~full_q;
   assign pop         = out_ready_i & ~empty_q;
   assign in_ready_o  = ~full_q;
   assign out_valid_o = ~empty_q;
   assign out_data_o  = mem[rd_ptr_q];
   assign count_d     = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data_i;
      end
   end

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
         full_q   <= 1'b0;
         empty_q  <= 1'b1;
      end else if (flush_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
         full_q   <= 1'b0;
         empty_q  <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         count_q <= count_d;
         full_q  <= (count_d == DEPTH[AW:0]);
         empty_q <= (count_d == {(AW+1){1'b0}});
      end
   end
endmodule

// *** qmtsr_host.sv ***
// Host processor model on the strobe bus of the slice.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/10ps
module qmtsr_host (
   input  wire        ref_clk_i,
   input  wire [15:0] bus_rdata_i,
   input  wire        bus_rvalid_i,
   output reg  [8:0]  bus_addr_o  = 9'h000,
   output reg         bus_wr_o    = 1'b0,
   output reg         bus_rd_o    = 1'b0,
   output reg  [1:0]  bus_be_o    = 2'b00,
   output reg  [15:0] bus_wdata_o = 16'h0000
);
   // Released lines show the inverse so stale values cannot match
   task wr(input [8:0] a, input [1:0] be, input [15:0] d);
      begin
         bus_addr_o  <= a;
         bus_be_o    <= be;
         bus_wdata_o <= d;
         bus_wr_o    <= 1'b1;
         @(posedge ref_clk_i);
         bus_wr_o    <= 1'b0;
         bus_addr_o  <= ~a;
         bus_wdata_o <= ~d;
         @(posedge ref_clk_i);
      end
   endtask
   task rd(input [8:0] a, output [15:0] d, output ok);
      integer i;
      begin
         bus_addr_o <= a;
         bus_rd_o   <= 1'b1;
         @(posedge ref_clk_i);
         bus_rd_o   <= 1'b0;
         bus_addr_o <= ~a;
         ok = 1'b0;
         d  = 16'hxxxx;
         for (i = 0; i < 4 && !ok; i = i + 1) begin
            @(posedge ref_clk_i);
            if (bus_rvalid_i === 1'b1) begin
               ok = 1'b1;
               d  = bus_rdata_i;
            end
         end
      end
   endtask
   task ctrl_wr(input [15:0] d, input fd);
      wr(9'h174, 2'b11, fd ? d : d & 16'hFBFF);
   endtask
   task flush_on(input [15:0] d);
      begin
         wr(9'h174, 2'b11, d & 16'hFFFE);
         wr(9'h174, 2'b11, (d & 16'hFFFE) | 16'h8000);
      end
   endtask
   task flush_off(input [15:0] d);
      wr(9'h174, 2'b11, d & 16'h7FFE);
   endtask
endmodule

// *** qmtsr_pause.v ***
// Pause timer: holds transmission for the received number of quanta.
// Assumes pause requests are one-cycle pulses from the receive MAC.
`timescale 1ns/10ps
`include "qmtsr_defines.vh"
module qmtsr_pause #(
   parameter QUANTUM_CYC = `QMTSR_QUANTUM_CYC
) (
   input  wire        ref_clk_i,
   input  wire        rst_n_i,
   input  wire        pause_en_i,
   input  wire        full_duplex_i,
   input  wire        pause_req_i,
   input  wire [15:0] pause_quanta_i,
   output wire        tx_hold_o
);
   localparam [15:0] QCYC_LAST = QUANTUM_CYC[15:0] - 16'h0001;

   reg  [15:0] quanta_q;
   reg  [15:0] presc_q;
   reg         hold_q;
   wire        active;

   // Half duplex or disabled: pause frames have no effect
   assign active    = pause_en_i & full_duplex_i;
   assign tx_hold_o = hold_q;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quanta_q <= 16'h0000;
         presc_q  <= 16'h0000;
         hold_q   <= 1'b0;
      end else if (!active) begin
         quanta_q <= 16'h0000;
         presc_q  <= 16'h0000;
         hold_q   <= 1'b0;
      end else if (pause_req_i) begin
         // A new pause frame restarts the timer, zero releases at once
         quanta_q <= pause_quanta_i;
         presc_q  <= 16'h0000;
         hold_q   <= (pause_quanta_i != 16'h0000);
      end else if (quanta_q != 16'h0000) begin
         if (presc_q == QCYC_LAST) begin
            presc_q  <= 16'h0000;
            quanta_q <= quanta_q - 16'h0001;
            hold_q   <= (quanta_q != 16'h0001);
         end else begin
            presc_q <= presc_q + 16'h0001;
         end
      end else begin
         hold_q <= 1'b0;
      end
   end
endmodule

// *** qmtsr_top.v ***
// Transmit status and receive control slice of the queue manager.
// Assumes host bus and MAC event inputs are synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "qmtsr_defines.vh"

// Notes on behaviour
// - Late collision of the finished frame shows as read-only bit 13.
// - Reaching the collision limit shows as read-only bit 12.
// - Transmit status holds the last frame, its 6-bit id in bits 5-0.
// - While flush bit 15 is set the receive queue and frame pointer clear.
// - With bit 14 set, UDP frames with a bad UDP checksum are dropped.
// - With bit 13 set, TCP frames with a bad TCP checksum are dropped.
// - With bit 12 set, IP frames with a bad header checksum are dropped.
// - Bit 11, reset one, admits unicast frames that pass the filter.
// - Bit 10 in full duplex obeys pause frames, else they are ignored.
// - Bit 9 set keeps CRC-error frames, clear drops them.
// - Bit 8 set admits multicast frames that pass the filter.
// - Bit 0 runs the receiver; clearing it stops after the current frame.
module qmtsr_top #(
   parameter DATA_W      = 8,
   parameter FIFO_DEPTH  = 16,
   parameter FIFO_AW     = 4,
   parameter QUANTUM_CYC = `QMTSR_QUANTUM_CYC
) (
   input  wire                     ref_clk_i,
   input  wire                     rst_n_i,

   // Host parallel bus
   input  wire [`QMTSR_ADDR_W-1:0] bus_addr_i,
   input  wire                     bus_wr_i,
   input  wire                     bus_rd_i,
   input  wire [1:0]               bus_be_i,
   input  wire [15:0]              bus_wdata_i,
   output wire [15:0]              bus_rdata_o,
   output wire                     bus_rvalid_o,

   // Transmit MAC completion events
   input  wire                     tx_done_i,
   input  wire                     tx_late_col_i,
   input  wire                     tx_max_col_i,
   input  wire [5:0]               tx_frame_id_i,

   // Receive MAC stream
   input  wire                     rx_valid_i,
   input  wire [DATA_W-1:0]        rx_data_i,
   input  wire                     rx_sof_i,
   input  wire                     rx_eof_i,
   output wire                     rx_ready_o,

   // Frame attributes, valid with rx_eof_i
   input  wire                     rx_crc_err_i,
   input  wire                     rx_is_ip_i,
   input  wire                     rx_ip_bad_i,
   input  wire                     rx_is_tcp_i,
   input  wire                     rx_tcp_bad_i,
   input  wire                     rx_is_udp_i,
   input  wire                     rx_udp_bad_i,
   input  wire                     rx_is_ucast_i,
   input  wire                     rx_ucast_pass_i,
   input  wire                     rx_is_mcast_i,
   input  wire                     rx_mcast_pass_i,
   input  wire                     rx_lower_accept_i,

   // Pause frames and duplex state
   input  wire                     full_duplex_i,
   input  wire                     pause_req_i,
   input  wire [15:0]              pause_quanta_i,
   output wire                     tx_hold_o,

   // Receive queue side
   output wire                     q_valid_o,
   output wire [DATA_W-1:0]        q_data_o,
   output wire                     q_last_o,
   output wire                     q_drop_o,
   input  wire                     q_ready_i,

   // Control levels for the rest of the receive path
   output wire                     receive_run_en_o,
   output wire                     rx_queue_flush_o,
   output wire [10:0]              rx_frame_ptr_o
);
   localparam FW = DATA_W + 2;

   localparam [1:0] RX_IDLE = 2'd0;
   localparam [1:0] RX_TAKE = 2'd1;
   localparam [1:0] RX_SKIP = 2'd2;

   // Transmit status fields
   reg              late_collision_flag_q;
   reg              collision_limit_flag_q;
   reg  [5:0]       sent_frame_id_q;

   // Receive control fields
   reg              rx_queue_flush_q;
   reg              udp_checksum_check_en_q;
   reg              tcp_checksum_check_en_q;
   reg              ip_checksum_check_en_q;

   reg              unicast_filter_en_q;
   reg              pause_honour_en_q;
   reg              crc_error_accept_en_q;
   reg              multicast_filter_en_q;

   reg              receive_run_en_q;

   reg  [15:0]      rdata_q;
   reg              rvalid_q;

   reg  [1:0]       rx_state_q;
   reg  [1:0]       rx_state_d;
   reg  [10:0]      frame_ptr_q;

   wire [15:0]      tx_status_word;

   wire [15:0]      rx_ctrl_word;

   wire             sel_tx_status;
   wire             sel_rx_ctrl;

   wire             wr_lo;
   wire             wr_hi;

   wire             fifo_in_ready;
   wire             fifo_out_valid;
   wire [FW-1:0]    fifo_out_data;

   wire             beat;
   wire             take_beat;

   wire             csum_drop;
   wire             crc_drop;
   wire             addr_accept;
   wire             frame_drop;

   wire [FW-1:0]    fifo_in_data;
   wire             fifo_in_valid;

   // Register read view
   assign tx_status_word = {2'b00,
                            late_collision_flag_q,
                            collision_limit_flag_q,
                            6'b00_0000,
                            sent_frame_id_q};

   assign rx_ctrl_word   = {rx_queue_flush_q,
                            udp_checksum_check_en_q,
                            tcp_checksum_check_en_q,
                            ip_checksum_check_en_q,
                            unicast_filter_en_q,
                            pause_honour_en_q,
                            crc_error_accept_en_q,
                            multicast_filter_en_q,
                            7'b000_0000,
                            receive_run_en_q};

   // Reads ignore the byte enables
   assign sel_tx_status = (bus_addr_i == `QMTSR_TX_STATUS_ADDR);
   assign sel_rx_ctrl   = (bus_addr_i == `QMTSR_RX_CTRL_ONE_ADDR);

   assign wr_lo         = bus_wr_i & sel_rx_ctrl & bus_be_i[0];
   assign wr_hi         = bus_wr_i & sel_rx_ctrl & bus_be_i[1];

   // Host read: one-cycle latency, unmapped reads return zero
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= bus_rd_i;

         if (bus_rd_i) begin
            if (sel_tx_status) begin
               rdata_q <= tx_status_word;
            end else if (sel_rx_ctrl) begin
               rdata_q <= rx_ctrl_word;
            end else begin
               rdata_q <= 16'h0000;
            end
         end
      end
   end

   // Transmit status: all fields replaced at once per finished frame
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         late_collision_flag_q  <= 1'b0;
         collision_limit_flag_q <= 1'b0;
         sent_frame_id_q        <= 6'h00;
      end else if (tx_done_i) begin
         late_collision_flag_q  <= tx_late_col_i;
         collision_limit_flag_q <= tx_max_col_i;
         sent_frame_id_q        <= tx_frame_id_i;
      end
   end

   // Receive control register, byte lanes written separately
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_queue_flush_q        <= 1'b0;
         udp_checksum_check_en_q <= 1'b0;
         tcp_checksum_check_en_q <= 1'b0;
         ip_checksum_check_en_q  <= 1'b0;
         unicast_filter_en_q     <= 1'b1;
         pause_honour_en_q       <= 1'b0;
         crc_error_accept_en_q   <= 1'b0;
         multicast_filter_en_q   <= 1'b0;
         receive_run_en_q        <= 1'b0;
      end else begin
         if (wr_hi) begin
            rx_queue_flush_q        <= bus_wdata_i[`QMTSR_RXC_FLUSH];
            udp_checksum_check_en_q <= bus_wdata_i[`QMTSR_RXC_UDP_CHK];
            tcp_checksum_check_en_q <= bus_wdata_i[`QMTSR_RXC_TCP_CHK];
            ip_checksum_check_en_q  <= bus_wdata_i[`QMTSR_RXC_IP_CHK];
            unicast_filter_en_q     <= bus_wdata_i[`QMTSR_RXC_UCAST_FILT];
            pause_honour_en_q       <= bus_wdata_i[`QMTSR_RXC_PAUSE_EN];
            crc_error_accept_en_q   <= bus_wdata_i[`QMTSR_RXC_CRC_ACCEPT];
            multicast_filter_en_q   <= bus_wdata_i[`QMTSR_RXC_MCAST_FILT];
         end

         if (wr_lo) begin
            receive_run_en_q <= bus_wdata_i[`QMTSR_RXC_RUN_EN];
         end
      end
   end

   // Frame verdict, taken on the last beat
   assign csum_drop   = (udp_checksum_check_en_q & rx_is_udp_i & rx_udp_bad_i)
                      | (tcp_checksum_check_en_q & rx_is_tcp_i & rx_tcp_bad_i)
                      | (ip_checksum_check_en_q  & rx_is_ip_i  & rx_ip_bad_i);
   assign crc_drop    = rx_crc_err_i & ~crc_error_accept_en_q;

   assign addr_accept = rx_lower_accept_i
                      | (rx_is_ucast_i & unicast_filter_en_q & rx_ucast_pass_i)
                      | (rx_is_mcast_i & multicast_filter_en_q & rx_mcast_pass_i);

   assign frame_drop  = csum_drop | crc_drop | ~addr_accept;

   // A beat is a byte the MAC hands over
   assign beat = rx_valid_i & fifo_in_ready;

   // Receive gate: a frame is taken only if running at its first beat
   always @* begin
      rx_state_d = rx_state_q;
      case (rx_state_q)
         RX_IDLE: begin
            if (beat & rx_sof_i & ~rx_eof_i) begin
               rx_state_d = receive_run_en_q ? RX_TAKE : RX_SKIP;
            end
         end

         RX_TAKE: begin
            // Clearing run enable mid-frame lets the frame finish
            if (beat & rx_eof_i) begin
               rx_state_d = RX_IDLE;
            end
         end

         RX_SKIP: begin
            if (beat & rx_eof_i) begin
               rx_state_d = RX_IDLE;
            end
         end

         default: begin
            rx_state_d = RX_IDLE;
         end
      endcase
   end

   // Flush swallows every beat
   assign take_beat = beat & ~rx_queue_flush_q &
                      (((rx_state_q == RX_IDLE) & rx_sof_i & receive_run_en_q) |
                       (rx_state_q == RX_TAKE));

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_state_q  <= RX_IDLE;
         frame_ptr_q <= 11'h000;
      end else if (rx_queue_flush_q) begin
         // Flush aborts the frame in progress and rewinds the pointer
         rx_state_q  <= (rx_state_q == RX_IDLE) ? RX_IDLE : RX_SKIP;
         frame_ptr_q <= 11'h000;
      end else begin
         rx_state_q <= rx_state_d;

         if (take_beat & rx_eof_i) begin
            frame_ptr_q <= 11'h000;
         end else if (take_beat) begin
            frame_ptr_q <= frame_ptr_q + 11'h001;
         end
      end
   end

   // Drop verdict travels with the last beat; the queue frees the frame
   assign fifo_in_data  = {rx_eof_i & frame_drop, rx_eof_i, rx_data_i};
   assign fifo_in_valid = take_beat;

   qmtsr_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (rx_queue_flush_q),
      .in_valid_i  (fifo_in_valid),
      .in_data_i   (fifo_in_data),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (q_ready_i)
   );

   qmtsr_pause #(
      .QUANTUM_CYC (QUANTUM_CYC)
   ) u_pause (
      .ref_clk_i      (ref_clk_i),
      .rst_n_i        (rst_n_i),
      .pause_en_i     (pause_honour_en_q),
      .full_duplex_i  (full_duplex_i),
      .pause_req_i    (pause_req_i),
      .pause_quanta_i (pause_quanta_i),
      .tx_hold_o      (tx_hold_o)
   );

   // Stall reaches the MAC even while a frame is being skipped
   assign rx_ready_o       = fifo_in_ready;

   assign q_valid_o        = fifo_out_valid;
   assign q_data_o         = fifo_out_data[DATA_W-1:0];
   assign q_last_o         = fifo_out_data[DATA_W];
   assign q_drop_o         = fifo_out_data[DATA_W+1];

   assign bus_rdata_o      = rdata_q;
   assign bus_rvalid_o     = rvalid_q;

   assign receive_run_en_o = receive_run_en_q;
   assign rx_queue_flush_o = rx_queue_flush_q;
   assign rx_frame_ptr_o   = frame_ptr_q;
endmodule

// *** tb.sv ***
// Bench of the transmit status and receive control slice.
// Assumes a 5 ns clock; the pause quantum is cut to 4 cycles.
`timescale 1ns/10ps
module tb;
   localparam [15:0] QC = 16'h0004;
   reg         ref_clk_i      = 1'b0;
   reg         rst_n_i        = 1'b0;
   reg         tx_done_i      = 1'b0;
   reg         tx_late_col_i  = 1'b0;
   reg         tx_max_col_i   = 1'b0;
   reg  [5:0]  tx_frame_id_i  = 6'h00;
   reg         rx_valid_i     = 1'b0;
   reg  [7:0]  rx_data_i      = 8'h00;
   reg         rx_sof_i       = 1'b0;
   reg         rx_eof_i       = 1'b0;
   reg  [11:0] attr           = 12'h001;
   reg         full_duplex_i  = 1'b1;
   reg         pause_req_i    = 1'b0;
   reg  [15:0] pause_quanta_i = 16'h0000;
   reg         q_ready_i      = 1'b1;
   wire [8:0]  bus_addr_i;
   wire [1:0]  bus_be_i;
   wire [15:0] bus_wdata_i, bus_rdata_o;
   wire        bus_wr_i, bus_rd_i, bus_rvalid_o, rx_ready_o, tx_hold_o;
   wire        q_valid_o, q_last_o, q_drop_o, receive_run_en_o, rx_queue_flush_o;
   wire [7:0]  q_data_o;
   wire [10:0] rx_frame_ptr_o;
   integer     miscompares = 0, samples_checked = 0, pop_cnt = 0, r, n, c;
   reg  [7:0]  pop_data = 8'h00;
   reg         pop_drop = 1'b0, pop_last = 1'b0;
   // Row: control, attributes, drop
   reg  [28:0] rows [0:10] = '{
      {16'h0001, 12'h001, 1'b0}, {16'h0001, 12'h801, 1'b1}, {16'h0201, 12'h801, 1'b0},
      {16'h4001, 12'h061, 1'b1}, {16'h0001, 12'h061, 1'b0}, {16'h2001, 12'h181, 1'b1},
      {16'h1001, 12'h601, 1'b1}, {16'h0801, 12'h018, 1'b0}, {16'h0001, 12'h018, 1'b1},
      {16'h0101, 12'h006, 1'b0}, {16'h0001, 12'h006, 1'b1}};
   qmtsr_host qmtsr_host_inst (
      .ref_clk_i, .bus_rdata_i(bus_rdata_o), .bus_rvalid_i(bus_rvalid_o),
      .bus_addr_o(bus_addr_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
      .bus_be_o(bus_be_i), .bus_wdata_o(bus_wdata_i));
   qmtsr_top #(.QUANTUM_CYC(QC)) qmtsr_top_inst (
      .*, .rx_crc_err_i(attr[11]), .rx_is_ip_i(attr[10]),
      .rx_ip_bad_i(attr[9]), .rx_is_tcp_i(attr[8]), .rx_tcp_bad_i(attr[7]),
      .rx_is_udp_i(attr[6]), .rx_udp_bad_i(attr[5]), .rx_is_ucast_i(attr[4]),
      .rx_ucast_pass_i(attr[3]), .rx_is_mcast_i(attr[2]), .rx_mcast_pass_i(attr[1]),
      .rx_lower_accept_i(attr[0]));
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (q_valid_o === 1'b1 && q_ready_i) begin
         pop_cnt  <= pop_cnt + 1;
         pop_data <= q_data_o;
         pop_drop <= q_drop_o;
         pop_last <= q_last_o;
      end
   end
   task stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task check(input [15:0] got, input [15:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task fail_wait;
      miscompares = miscompares + 1;
      stop_test();
   endtask
   task rd_chk(input [8:0] a, input [15:0] exp);
      reg [15:0] d;
      reg        ok;
      begin
         qmtsr_host_inst.rd(a, d, ok);
         if (!ok)
            fail_wait();
         check(d, exp);
      end
   endtask
   task tx_evt(input l, input m, input [5:0] id);
      tx_done_i     <= 1'b1;
      tx_late_col_i <= l;
      tx_max_col_i  <= m;
      tx_frame_id_i <= id;
      @(posedge ref_clk_i);
   endtask
   task beat(input s, input e, input [7:0] d);
      integer i;
      begin
         rx_valid_i <= 1'b1;
         rx_sof_i   <= s;
         rx_eof_i   <= e;
         rx_data_i  <= d;
         i = 0;
         do begin
            @(posedge ref_clk_i);
            i = i + 1;
         end while (rx_ready_o !== 1'b1 && i < 40);
         if (rx_ready_o !== 1'b1)
            fail_wait();
      end
   endtask
   task frame(input integer len, input [7:0] b, input e);
      integer k;
      begin
         for (k = 0; k < len; k = k + 1)
            beat(k == 0, e && k == len - 1, b + k[7:0]);
         rx_valid_i <= 1'b0;
         rx_data_i  <= ~rx_data_i;
      end
   endtask
   task wait_pops(input integer target);
      integer i;
      for (i = 0; i < 80 && pop_cnt < target; i = i + 1)
         @(posedge ref_clk_i);
      if (pop_cnt < target)
         fail_wait();
   endtask
   task pause_cnt(input [15:0] q, output integer cnt);
      integer i;
      begin
         pause_quanta_i <= q;
         pause_req_i    <= 1'b1;
         @(posedge ref_clk_i);
         pause_req_i    <= 1'b0;
         pause_quanta_i <= ~q;
         cnt = 0;
         for (i = 0; i < 30; i = i + 1) begin
            @(posedge ref_clk_i);
            if (tx_hold_o === 1'b1)
               cnt = cnt + 1;
         end
      end
   endtask
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      for (r = 0; r < 11; r = r + 1) begin
         qmtsr_host_inst.ctrl_wr(rows[r][28:13], 1'b1);
         attr <= rows[r][12:1];
         n = pop_cnt + 2;
         frame(2, r[7:0], 1'b1);
         wait_pops(n);
         check({15'h0000, pop_drop}, {15'h0000, rows[r][0]});
         check({8'h00, pop_data}, {8'h00, r[7:0] + 8'h01});
      end
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_chk(9'h174, 16'h0800);
      rd_chk(9'h172, 16'h0000);
      qmtsr_host_inst.wr(9'h174, 2'b11, 16'h7FFF);
      rd_chk(9'h174, 16'h7F01);
      qmtsr_host_inst.wr(9'h174, 2'b01, 16'h0000);
      rd_chk(9'h174, 16'h7F00);
      qmtsr_host_inst.wr(9'h172, 2'b11, 16'hFFFF);
      rd_chk(9'h172, 16'h0000);
      rd_chk(9'h17E, 16'h0000);
      tx_evt(1'b1, 1'b0, 6'h05);
      tx_evt(1'b0, 1'b1, 6'h3F);
      tx_done_i <= 1'b0;
      rd_chk(9'h172, 16'h103F);
      tx_evt(1'b1, 1'b0, 6'h05);
      tx_done_i <= 1'b0;
      rd_chk(9'h172, 16'h2005);
      qmtsr_host_inst.ctrl_wr(16'h0401, 1'b1);
      pause_cnt(16'h0002, c);
      check(c[15:0], 16'h0002 * QC);
      qmtsr_host_inst.ctrl_wr(16'h0001, 1'b1);
      pause_cnt(16'h0002, c);
      check(c[15:0], 16'h0000);
      full_duplex_i <= 1'b0;
      qmtsr_host_inst.ctrl_wr(16'h0401, 1'b0);
      pause_cnt(16'h0002, c);
      check(c[15:0], 16'h0000);
      full_duplex_i <= 1'b1;
      q_ready_i <= 1'b0;
      n = pop_cnt + 17;
      frame(16, 8'h80, 1'b0);
      @(posedge ref_clk_i);
      check({15'h0000, rx_ready_o}, 16'h0000);
      q_ready_i <= 1'b1;
      beat(1'b0, 1'b1, 8'h90);
      rx_valid_i <= 1'b0;
      wait_pops(n);
      check({14'h0000, pop_last, q_valid_o}, 16'h0002);
      check({8'h00, pop_data}, 16'h0090);
      q_ready_i <= 1'b0;
      frame(3, 8'hA0, 1'b1);
      qmtsr_host_inst.flush_on(16'h0001);
      @(posedge ref_clk_i);
      check({5'h00, rx_frame_ptr_o}, 16'h0000);
      check({15'h0000, q_valid_o}, 16'h0000);
      qmtsr_host_inst.flush_off(16'h0001);
      n = pop_cnt;
      q_ready_i <= 1'b1;
      frame(3, 8'hB0, 1'b1);
      repeat (8) @(posedge ref_clk_i);
      check(pop_cnt[15:0], n[15:0]);
      stop_test();
   end
endmodule
bind qmtsr_top qmtsr_chk qmtsr_chk_inst (.*);
